// [inc/wdit_pkg.sv]
// constants, types and bus carrier shared by the watchdog/interval timer
//
// Functional notes
// - upper mode bit one selects watchdog
// - select codes give 2^11..2^17 clock periods
// - writing run one starts the count
// - every run write clears and restarts counter
// - watchdog overflow gives reset or nmi
// - watchdog runs in halt, stops in stop
// - detection may be 0.8% short
// - counting stops on subsystem cpu clock
// - mode 01 is repeating interval timer
// - interval mode starts on run write
// - interval overflow request is maskable
// - interval interrupt has highest maskable priority
// - interval runs in halt, stops in stop
// - after watchdog select, no interval mode
// - first interval may be 0.8% short
// - mode bits decode stop/interval/nmi/reset
// - run bit cannot be cleared by software
// - both mode bits are sticky
// - reset clears mode register to zero
package wdit_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] WDIT_ADDR_MODE = 16'hfff9;  // wd_mode_reg
    localparam logic [15:0] WDIT_ADDR_CSEL = 16'hff42;  // wd_clock_select_reg
    localparam logic [15:0] WDIT_ADDR_IRQ  = 16'hff44;  // interval request flag and mask

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          WDIT_RUN_BIT   = 7;
    localparam int          WDIT_UPPER_BIT = 4;
    localparam int          WDIT_LOWER_BIT = 3;
    localparam int          WDIT_FLAG_BIT  = 0;
    localparam int          WDIT_MASK_BIT  = 1;
    localparam logic [7:0]  WDIT_MODE_RST  = 8'h00;
    localparam logic [2:0]  WDIT_CSEL_RST  = 3'h0;
    localparam logic        WDIT_MASK_RST  = 1'b1;

    // ------------------------------------------------------------
    // timing: prescaler taps give clk/2^4..2^10, counter adds 2^7
    // ------------------------------------------------------------
    localparam int          WDIT_PRE_W     = 10;
    localparam int          WDIT_CNT_W     = 7;
    localparam int          WDIT_TAP0      = 3;
    localparam int          WDIT_TAP_STEP  = 2;
    localparam int          WDIT_NTAPS     = 4;

    // highest fixed priority level among maskable sources
    localparam logic [1:0]  WDIT_PRIO_TOP  = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WDIT_STOPPED,
        WDIT_INTERVAL,
        WDIT_WD_NMI,
        WDIT_WD_RESET
    } wdit_mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } wdit_bus_req_s;

endpackage

// [design/wdit_prescaler.sv]
// prescaler counting only while run_en is high, with selectable tick tap for the timer counter
`timescale 1ns/1ps
module wdit_prescaler (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run_en,
    input  wire logic [2:0] csel,
    // tick towards the counter
    output logic            tick
);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [wdit_pkg::WDIT_PRE_W-1:0] pre_r;      // divider state
    logic [wdit_pkg::WDIT_NTAPS-1:0] carry;      // carry out of each tap
    logic                            tick_r;     // registered tick
    logic                            tick_nxt;   // next tick

    // one carry per selectable tap: all bits up to the tap are ones
    genvar g;
    generate
        for (g = 0; g < wdit_pkg::WDIT_NTAPS; g++) begin : g_tap
            assign carry[g] = &pre_r[wdit_pkg::WDIT_TAP0 + g*wdit_pkg::WDIT_TAP_STEP:0];
        end
    endgenerate

    // code bit 0 is ignored; odd codes are not legal anyway
    assign tick_nxt = run_en && carry[csel[2:1]];
    assign tick     = tick_r;

    // prescaler never clears on restart, so the first tick after a
    // restart may come early; that is the short-period slack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            if (run_en) begin
                pre_r <= pre_r + 1'b1;
            end
            tick_r <= tick_nxt;
        end
    end

endmodule

// [design/wdit_timer.sv]
// watchdog / interval timer: mode registers, counter, overflow actions
`timescale 1ns/1ps
module wdit_timer #(
    parameter int CNT_W = wdit_pkg::WDIT_CNT_W  // ticks per period = 2^CNT_W
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // register port
    input  wire wdit_pkg::wdit_bus_req_s bus_req,
    output logic [7:0]                   rd_data,
    // processor state
    input  wire logic                    stop_mode,
    input  wire logic                    cpu_on_subclock,
    // overflow actions
    output logic                         nmi_req,
    output logic                         sys_reset_req,
    output logic                         interval_irq_request,
    output logic [1:0]                   interval_irq_prio
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic             run_r;                 // run bit, sticky
    logic             upper_r;               // wd_mode_upper_bit, sticky
    logic             lower_r;               // wd_mode_lower_bit, sticky
    logic [2:0]       csel_r;                // wd_clock_select_reg field
    logic             irq_flag_r;            // interval request flag
    logic             irq_mask_r;            // interval_irq_mask
    logic [CNT_W-1:0] cnt_r;                 // period counter
    logic             nmi_r;                 // nmi pulse
    logic             sysrst_r;              // reset request pulse
    logic [7:0]       rdata_r;               // read data register

    // next values
    logic             run_nxt;
    logic             upper_nxt;
    logic             lower_nxt;
    logic             irq_flag_nxt;
    logic [CNT_W-1:0] cnt_nxt;
    logic [7:0]       rdata_nxt;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire        hit_mode = bus_req.addr == wdit_pkg::WDIT_ADDR_MODE;
    wire        hit_csel = bus_req.addr == wdit_pkg::WDIT_ADDR_CSEL;
    wire        hit_irq  = bus_req.addr == wdit_pkg::WDIT_ADDR_IRQ;

    // write strobes per register
    wire        wr_mode  = bus_req.wr && hit_mode;
    wire        wr_csel  = bus_req.wr && hit_csel;
    wire        wr_irq   = bus_req.wr && hit_irq;
    wire  [7:0] wdata    = bus_req.wdata;

    // a run write both starts and clears the counter
    wire        restart  = wr_mode && wdata[wdit_pkg::WDIT_RUN_BIT];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wdit_pkg::wdit_mode_e mode;

    // 00 stop, 01 interval, 10 nmi, 11 reset
    assign mode = upper_r ? (lower_r ? wdit_pkg::WDIT_WD_RESET : wdit_pkg::WDIT_WD_NMI)
                          : (lower_r ? wdit_pkg::WDIT_INTERVAL : wdit_pkg::WDIT_STOPPED);

    // ------------------------------------------------------------
    // count enable
    // ------------------------------------------------------------
    // halt does not appear here: the timer simply keeps running while
    // the core is halted; only stop and the subsystem cpu clock freeze it
    wire count_en = run_r && (mode != wdit_pkg::WDIT_STOPPED)
                    && !stop_mode
                    && !cpu_on_subclock;

    // registered tick from the prescaler
    wire tick;

    // prescaler and tick selection
    wdit_prescaler u_pre (
        .clk    (clk),
        .rst_n  (rst_n),
        .run_en (count_en),
        .csel   (csel_r),
        .tick   (tick)
    );

    // ------------------------------------------------------------
    // counter and overflow
    // ------------------------------------------------------------
    // a restart in the same cycle as the last tick wins: no overflow
    wire cnt_full = &cnt_r;
    wire ovf      = tick && cnt_full && !restart;

    // counter wraps on overflow in every mode, so the interval timer
    // repeats without software help
    assign cnt_nxt = restart ? '0 :
                     tick    ? cnt_r + 1'b1 : cnt_r;

    // overflow action per mode
    wire nmi_nxt    = ovf && (mode == wdit_pkg::WDIT_WD_NMI);
    wire sysrst_nxt = ovf && (mode == wdit_pkg::WDIT_WD_RESET);
    wire irq_set    = ovf && (mode == wdit_pkg::WDIT_INTERVAL);

    // ------------------------------------------------------------
    // sticky mode bits
    // ------------------------------------------------------------
    // writes of zero never clear run or the mode bits
    assign run_nxt   = run_r   | restart;
    assign upper_nxt = upper_r | (wr_mode && wdata[wdit_pkg::WDIT_UPPER_BIT]);

    // the lower bit may still be set after the upper one: that moves the
    // watchdog from nmi to reset but can never reach interval mode,
    // since the upper bit stays one until reset
    assign lower_nxt = lower_r | (wr_mode && wdata[wdit_pkg::WDIT_LOWER_BIT]);

    // ------------------------------------------------------------
    // interval request flag
    // ------------------------------------------------------------
    // software clears by writing zero to the flag bit; an overflow in the
    // same cycle wins over the clear so no interval is lost
    wire irq_clr = wr_irq && !wdata[wdit_pkg::WDIT_FLAG_BIT];
    assign irq_flag_nxt = irq_set | (irq_flag_r & ~irq_clr);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // read images; unused bits read zero
    wire [7:0] mode_rd = {run_r, 2'h0, upper_r, lower_r, 3'h0};
    wire [7:0] csel_rd = {5'h00, csel_r};
    wire [7:0] irq_rd  = {6'h00, irq_mask_r, irq_flag_r};

    // unmapped addresses and idle cycles read as zero
    assign rdata_nxt = !bus_req.rd ? 8'h00   :
                       hit_mode    ? mode_rd :
                       hit_csel    ? csel_rd :
                       hit_irq     ? irq_rd  : 8'h00;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data              = rdata_r;

    // action pulses straight from flops
    assign nmi_req              = nmi_r;
    assign sys_reset_req        = sysrst_r;
    // maskable request towards the interrupt controller
    assign interval_irq_request = irq_flag_r && !irq_mask_r;
    // fixed top level, no software can lower it
    assign interval_irq_prio    = wdit_pkg::WDIT_PRIO_TOP;

    // ------------------------------------------------------------
    // mode register, cleared by reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // mode register back to zero, timer idle
            run_r   <= wdit_pkg::WDIT_MODE_RST[wdit_pkg::WDIT_RUN_BIT];
            upper_r <= wdit_pkg::WDIT_MODE_RST[wdit_pkg::WDIT_UPPER_BIT];
            lower_r <= wdit_pkg::WDIT_MODE_RST[wdit_pkg::WDIT_LOWER_BIT];
        end else begin
            // bits only ever gain ones here
            run_r   <= run_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
        end
    end

    // ------------------------------------------------------------
    // clock select and interrupt control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // select 000, request masked
            csel_r     <= wdit_pkg::WDIT_CSEL_RST;
            irq_mask_r <= wdit_pkg::WDIT_MASK_RST;
            irq_flag_r <= 1'b0;
        end else begin
            // software writes, then flag update
            if (wr_csel) begin
                csel_r <= wdata[2:0];
            end
            if (wr_irq) begin
                irq_mask_r <= wdata[wdit_pkg::WDIT_MASK_BIT];
            end
            irq_flag_r <= irq_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // counter, action pulses, read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // counter idle, no pulses
            cnt_r    <= '0;
            nmi_r    <= 1'b0;
            sysrst_r <= 1'b0;
            rdata_r  <= 8'h00;
        end else begin
            // everything steps every clock
            cnt_r    <= cnt_nxt;
            nmi_r    <= nmi_nxt;
            sysrst_r <= sysrst_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // counter reads zero right after a run write
    restart_clears_a: assert property (restart |=> cnt_r == '0)
        else $error("counter not cleared by run write");

    // counting starts only once run has been written
    start_needs_run_a: assert property (!run_r |-> cnt_r == '0)
        else $error("counter moved before run was set");

    // run never drops while reset is released
    run_sticky_a: assert property (run_r |=> run_r)
        else $error("run bit cleared by software");

    // both mode bits stay set
    mode_sticky_a: assert property (
        (upper_r || lower_r) |=> (upper_r >= $past(upper_r)) && (lower_r >= $past(lower_r)))
        else $error("mode bit cleared by software");

    // once the watchdog is selected interval mode never comes back
    no_interval_a: assert property (
        upper_r |=> upper_r && mode != wdit_pkg::WDIT_INTERVAL)
        else $error("interval mode reached after watchdog select");

    // nmi follows an overflow in nmi mode, one cycle later
    nmi_cause_a: assert property (
        tick && cnt_full && !restart && upper_r && !lower_r |=> nmi_req)
        else $error("nmi missing after watchdog overflow");

    // reset request only in reset mode and only after a full counter
    reset_cause_a: assert property (
        sys_reset_req |-> $past(upper_r) && $past(lower_r) && $past(cnt_full) && $past(tick))
        else $error("reset request without overflow in reset mode");

    // interval overflow sets the flag and the counter wraps to zero
    interval_wrap_a: assert property (
        irq_set |=> irq_flag_r && cnt_r == '0 && !nmi_req && !sys_reset_req)
        else $error("interval overflow lost or no wrap");

    // interval request is masked by the mask flag
    irq_masked_a: assert property (
        irq_mask_r |-> !interval_irq_request)
        else $error("masked interval request reached the output");

    // stop mode and subsystem clock freeze the counter
    freeze_hold_a: assert property (
        (stop_mode || cpu_on_subclock) && !restart ##1 (stop_mode || cpu_on_subclock)
        && !restart |=> $stable(cnt_r))
        else $error("counter moved while stopped");

    // the counter only steps on a prescaler tick
    step_on_tick_a: assert property (
        !restart && !tick |=> $stable(cnt_r))
        else $error("counter stepped without a tick");

    // reset leaves the mode register at zero
    reset_clear_a: assert property (
        @(posedge clk) disable iff (1'b0) !rst_n |=> !run_r && !upper_r && !lower_r)
        else $error("mode register not cleared by reset");

    // mode register reads back its sticky bits
    mode_read_a: assert property (
        bus_req.rd && hit_mode |=> rd_data == {run_r, 2'h0, upper_r, lower_r, 3'h0})
        else $error("mode register read mismatch");

    // unmasked flag reaches the controller
    irq_pass_a: assert property (
        irq_flag_r && !irq_mask_r |-> interval_irq_request)
        else $error("unmasked request lost");

    // nmi only after an overflow in nmi mode
    nmi_only_a: assert property (
        nmi_req |-> $past(ovf) && $past(upper_r) && !$past(lower_r))
        else $error("stray nmi");

    // the flag rises only in interval mode
    irq_mode_a: assert property (
        $rose(irq_flag_r) |-> $past(lower_r) && !$past(upper_r))
        else $error("flag set outside interval");

    // mode 00 never counts
    stop_idle_a: assert property (
        mode == wdit_pkg::WDIT_STOPPED |-> cnt_r == '0 && !tick)
        else $error("counting in mode 00");

    // every overflow wraps the counter
    wrap_all_a: assert property (
        ovf |=> cnt_r == '0)
        else $error("no wrap");

    // action pulses last one cycle
    pulse_once_a: assert property (
        nmi_req || sys_reset_req |=> !nmi_req && !sys_reset_req)
        else $error("pulse too long");

    // no tick once a freeze has lasted a cycle
    tick_frozen_a: assert property (
        (stop_mode || cpu_on_subclock) [*2] |-> !tick)
        else $error("tick while frozen");

    // clock select moves only on its write
    csel_hold_a: assert property (
        !wr_csel |=> $stable(csel_r))
        else $error("select changed");

    // no tick before run is set
    tick_run_a: assert property (
        !run_r |-> !tick)
        else $error("tick before run");

    // a restart on the last tick cancels the overflow
    restart_wins_a: assert property (
        restart && tick && cnt_full |=> !nmi_req && !sys_reset_req)
        else $error("overflow despite restart");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    nmi_seen_c:      cover property (nmi_req);
    reset_seen_c:    cover property (sys_reset_req);
    irq_seen_c:      cover property (interval_irq_request);
    set_wins_c:      cover property (irq_set && irq_clr);
    freeze_c:        cover property (stop_mode && run_r);

endmodule

// [verification/wdit_core_model.sv]
// core-side partner model: standby state lines and overflow action counters
`timescale 1ns/1ps
module wdit_core_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // standby requests from the program
    input  wire logic stop_cmd,
    input  wire logic sub_cmd,
    // state lines towards the timer
    output logic      stop_mode,
    output logic      cpu_on_subclock,
    // overflow actions from the timer
    input  wire logic nmi_req,
    input  wire logic sys_reset_req,
    // pulses seen by the core
    output int        nmi_cnt,
    output int        rst_cnt
);
    // ------------------------------------------------------------
    // standby state: lines move only on an edge, like the core latches
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stop_mode       <= 1'b0;
            cpu_on_subclock <= 1'b0;
        end else begin
            stop_mode       <= stop_cmd;
            cpu_on_subclock <= sub_cmd;
        end
    end
    // ------------------------------------------------------------
    // action counters: pulses are one cycle, so a level counts once
    // limitation: a reset request is only counted, the core is not reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmi_cnt <= 0;
            rst_cnt <= 0;
        end else begin
            nmi_cnt <= nmi_cnt + int'(nmi_req);
            rst_cnt <= rst_cnt + int'(sys_reset_req);
        end
    end
endmodule

// [verification/test_watchdog_interval_timer.sv]
// self-checking bench for the watchdog / interval timer
`timescale 1ns/1ps
module test_watchdog_interval_timer;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int           CW = 2;  // shortened counter: 4 ticks a period
    logic                    clk;
    logic                    rst_n;
    wdit_pkg::wdit_bus_req_s bus_req;
    logic [7:0]              rd_data;
    logic                    stop_cmd;
    logic                    sub_cmd;
    logic                    stop_mode;
    logic                    cpu_on_subclock;
    logic                    nmi_req;
    logic                    sys_reset_req;
    logic                    interval_irq_request;
    logic [1:0]              interval_irq_prio;
    int                      nmi_cnt;
    int                      rst_cnt;
    int                      error_cnt;
    int                      total_checks;
    int                      n;
    // clock and time-zero values
    initial begin
        clk = 1'b0; rst_n = 1'b0; bus_req = '0; stop_cmd = 1'b0; sub_cmd = 1'b0;
        error_cnt = 0; total_checks = 0;
    end
    always #20 clk = ~clk;
    // ------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------
    wdit_timer #(.CNT_W(CW)) dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .rd_data(rd_data), .stop_mode(stop_mode), .cpu_on_subclock(cpu_on_subclock),
        .nmi_req(nmi_req), .sys_reset_req(sys_reset_req),
        .interval_irq_request(interval_irq_request), .interval_irq_prio(interval_irq_prio));
    wdit_core_model u_core (.clk(clk), .rst_n(rst_n), .stop_cmd(stop_cmd), .sub_cmd(sub_cmd),
        .stop_mode(stop_mode), .cpu_on_subclock(cpu_on_subclock), .nmi_req(nmi_req),
        .sys_reset_req(sys_reset_req), .nmi_cnt(nmi_cnt), .rst_cnt(rst_cnt));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t %s seen %0h exp %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // reset held 20 cycles, then one edge with reset seen high
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    // one-cycle write; strobe is taken at the second edge
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    // one-cycle read; data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        check(rd_data, exp, msg);
    endtask
    // bounded wait: 0 interval request, 1 nmi, 2 reset request
    task automatic wait_for(input int sel, input int bound, output int cnt);
        logic s;
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
            s = (sel == 0) ? interval_irq_request : (sel == 1) ? nmi_req : sys_reset_req;
        end while (s !== 1'b1 && cnt < bound);
        if (s !== 1'b1) begin
            check(1'b0, 1'b1, "wait ran out");
            close_out();
        end
    endtask
    // ------------------------------------------------------------
    // scenario: reset values, stopped mode, sticky run bit
    // ------------------------------------------------------------
    task automatic t_reset_vals;
        do_reset();
        rd_chk(wdit_pkg::WDIT_ADDR_MODE, 8'h00, "mode reset");
        rd_chk(wdit_pkg::WDIT_ADDR_CSEL, 8'h00, "csel reset");
        rd_chk(wdit_pkg::WDIT_ADDR_IRQ, 8'h02, "irq reset");
        rd_chk(16'h1234, 8'h00, "unmapped read");
        check(interval_irq_prio, 2'h3, "priority");
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h80);  // run with mode 00: nothing counts
        repeat (150) @(posedge clk);
        rd_chk(wdit_pkg::WDIT_ADDR_IRQ, 8'h02, "mode 00 idle");
        check(nmi_cnt + rst_cnt, 0, "mode 00 action");
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h00);
        rd_chk(wdit_pkg::WDIT_ADDR_MODE, 8'h80, "run sticky");
    endtask
    // ------------------------------------------------------------
    // scenario: interval start, mask, and period for every even code
    // ------------------------------------------------------------
    task automatic t_interval;
        int p;
        do_reset();
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h08);  // mode 01 without run
        repeat (150) @(posedge clk);
        rd_chk(wdit_pkg::WDIT_ADDR_IRQ, 8'h02, "no run no flag");
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h88);
        repeat (70) @(posedge clk);
        rd_chk(wdit_pkg::WDIT_ADDR_IRQ, 8'h03, "flag while masked");
        check(interval_irq_request, 1'b0, "masked request");
        bus_wr(wdit_pkg::WDIT_ADDR_IRQ, 8'h00);  // clear flag, unmask
        for (int i = 0; i < 4; i++) begin
            p = (16 << (2 * i)) * (1 << CW);
            bus_wr(wdit_pkg::WDIT_ADDR_CSEL, 8'(2 * i));
            wait_for(0, 2 * p + 100, n);
            bus_wr(wdit_pkg::WDIT_ADDR_IRQ, 8'h00);
            wait_for(0, p + 100, n);
            check(n + 2, p, "interval period");
            bus_wr(wdit_pkg::WDIT_ADDR_IRQ, 8'h00);
        end
    endtask
    // ------------------------------------------------------------
    // scenario: watchdog restarts, nmi, sticky bits, reset mode
    // ------------------------------------------------------------
    task automatic t_watchdog;
        do_reset();
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h90);
        for (int i = 0; i < 5; i++) begin
            repeat (40) @(posedge clk);
            bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h80);
        end
        #1;
        check(nmi_cnt, 0, "restart keeps quiet");
        wait_for(1, 100, n);
        check(n >= 48 && n <= 66, 1'b1, "detection time");
        @(posedge clk);
        #1;
        check(nmi_req, 1'b0, "nmi one cycle");
        check(rst_cnt, 0, "no reset in nmi mode");
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h00);
        rd_chk(wdit_pkg::WDIT_ADDR_MODE, 8'h90, "bits sticky");
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h08);
        rd_chk(wdit_pkg::WDIT_ADDR_MODE, 8'h98, "no interval");
        wait_for(2, 100, n);
        check(nmi_cnt, 1, "reset mode no nmi");
        rd_chk(wdit_pkg::WDIT_ADDR_IRQ, 8'h02, "no flag in wd");
    endtask
    // ------------------------------------------------------------
    // scenario: stop mode and subsystem clock freeze counting
    // ------------------------------------------------------------
    task automatic t_freeze;
        logic seen;
        do_reset();
        bus_wr(wdit_pkg::WDIT_ADDR_IRQ, 8'h00);
        bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h88);
        wait_for(0, 80, n);
        for (int k = 0; k < 2; k++) begin
            bus_wr(wdit_pkg::WDIT_ADDR_IRQ, 8'h00);
            bus_wr(wdit_pkg::WDIT_ADDR_MODE, 8'h88);
            if (k == 0) stop_cmd <= 1'b1;
            else sub_cmd <= 1'b1;
            seen = 1'b0;
            repeat (300) begin
                @(posedge clk);
                #1;
                seen = seen | interval_irq_request;
            end
            check(seen, 1'b0, "frozen count");
            stop_cmd <= 1'b0;
            sub_cmd <= 1'b0;
            wait_for(0, 80, n);  // counting resumes after release
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        t_reset_vals();
        t_interval();
        t_watchdog();
        t_freeze();
        close_out();
    end
endmodule
